// file: core/wss_pkg.sv
// Constants and types shared by the waveform sequence slot block
package wss_pkg;

	// Sequencer address range
	localparam logic [7:0] SEQ_FIRST_ADDR = 8'h0f; // First slot played after go
	localparam logic [7:0] SEQ_LAST_ADDR  = 8'h16; // Eighth and last slot
	localparam int         SLOT_COUNT     = 8;     // Slots in one sequence

	// Register offsets held in this block
	localparam logic [7:0] SLOT_FOUR_ADDR = 8'h12; // Fourth slot register
	localparam logic [7:0] SLOT_FIVE_ADDR = 8'h13; // Fifth slot register

	// Field layout and reset values
	localparam int         DELAY_SEL_BIT  = 7;     // Delay select position
	localparam int         ENTRY_MSB      = 6;     // Top bit of entry value
	localparam logic [7:0] SLOT_RESET     = 8'h00; // Slot value after reset
	localparam logic [6:0] ENTRY_STOP     = 7'h00; // Entry that ends playback
	localparam logic [7:0] READ_UNMAPPED  = 8'h00; // Read of a foreign offset

	// Delay time base
	localparam int DELAY_UNIT_MS     = 10;     // One delay step in ms
	localparam int CLK_FREQ_KHZ      = 100000; // Core clock rate in kHz
	localparam int DELAY_UNIT_CYCLES = DELAY_UNIT_MS * CLK_FREQ_KHZ; // Cycles per step

	// One slot: select bit over seven-bit value
	typedef struct packed {
		logic       delay_sel;   // One: value is a delay
		logic [6:0] entry_value; // Effect index or delay steps
	} wss_slot_t;

	// Register access request
	typedef struct packed {
		logic       wr;    // Write strobe
		logic       rd;    // Read strobe
		logic [7:0] addr;  // Register offset
		logic [7:0] wdata; // Write data
	} wss_reg_req_t;

	// Sequencer states, Gray along idle-fetch-play
	typedef enum logic [1:0] {
		WSS_IDLE  = 2'b00, // Waiting for go
		WSS_FETCH = 2'b01, // Examining current slot
		WSS_PLAY  = 2'b11, // Effect playing
		WSS_WAIT  = 2'b10  // Timed idle
	} wss_state_t;

endpackage

// file: core/wss_sequencer.sv
// Waveform sequencer with slot four and five registers
// What this block does
// - Delay select set: value is idle time
// - Idle lasts value times ten milliseconds
// - Delay select clear: value is effect
// - Seven-bit value indexes the effect library
// - Go starts playback at first slot
// - After finishing, move to next slot
// - Stop after eighth slot processed
// - Zero value stops playback there
// - Slots reset to zero, read/write
`timescale 1ns/10ps
`default_nettype none

module wss_sequencer #(
	parameter int DELAY_UNIT_CYCLES = wss_pkg::DELAY_UNIT_CYCLES // Cycles per delay step
) (
	input  wire logic                      clk_in,           // Core clock, 100 MHz
	input  wire logic                      reset_in,         // Synchronous reset, high
	input  wire wss_pkg::wss_reg_req_t     reg_req_in,       // Register access request
	input  wire logic                      go_in,            // Start pulse from go bit
	input  wire wss_pkg::wss_slot_t [7:0]  other_slots_in,   // Slot contents held elsewhere
	input  wire logic                      effect_done_in,   // Library effect finished
	output logic [7:0]                     rd_data_out,      // Register read data
	output logic                           effect_start_out, // Pulse: fetch an effect
	output logic [6:0]                     effect_index_out, // Library index to play
	output logic                           delay_active_out, // Timed idle in progress
	output logic                           busy_out,         // Sequence running
	output logic                           seq_done_out,     // Pulse: sequence ended
	output logic [7:0]                     slot_addr_out     // Address of current slot
);

	// Width of the delay tick counter
	localparam int TW = $clog2(DELAY_UNIT_CYCLES + 1);
	localparam logic [TW-1:0] TICK_LOAD = TW'(DELAY_UNIT_CYCLES - 1);

	// Refuse a time base the counter cannot serve
	if (DELAY_UNIT_CYCLES < 1) begin : g_check_unit
		$error("DELAY_UNIT_CYCLES must be at least one");
	end

	// Slot registers
	wss_pkg::wss_slot_t slot_four_reg;  // Slot at offset sequence_slot_four
	wss_pkg::wss_slot_t slot_four_next; // Its next value
	wss_pkg::wss_slot_t slot_five_reg;  // Slot at offset sequence_slot_five
	wss_pkg::wss_slot_t slot_five_next; // Its next value
	logic [7:0]         rd_data_reg;    // Read data
	logic [7:0]         rd_data_next;   // Next read data

	// Named views of the held fields
	logic       slot_four_delay_select; // Slot four select bit
	logic [6:0] slot_four_entry_value;  // Slot four value
	logic       slot_five_delay_select; // Slot five select bit
	logic [6:0] slot_five_entry_value;  // Slot five value

	// Sequencer state
	wss_pkg::wss_state_t state_reg;    // Current state
	wss_pkg::wss_state_t state_next;   // Next state
	logic [7:0]          addr_reg;     // Current slot address
	logic [7:0]          addr_next;    // Next slot address
	logic [6:0]          unit_reg;     // Delay steps left
	logic [6:0]          unit_next;    // Next steps left
	logic [TW-1:0]       tick_reg;     // Cycles left in step
	logic [TW-1:0]       tick_next;    // Next cycles left
	logic                start_reg;    // Effect start pulse
	logic                start_next;   // Next start pulse
	logic [6:0]          index_reg;    // Effect index
	logic [6:0]          index_next;   // Next effect index
	logic                done_reg;     // Sequence end pulse
	logic                done_next;    // Next end pulse
	logic                delay_reg;    // Delay active flag
	logic                busy_reg;     // Busy flag
	logic                advance;      // Current slot finished
	logic [2:0]          slot_sel;     // Slot number from address
	wss_pkg::wss_slot_t  cur_slot;     // Contents of current slot

	// Field views
	assign slot_four_delay_select = slot_four_reg.delay_sel;
	assign slot_four_entry_value  = slot_four_reg.entry_value;
	assign slot_five_delay_select = slot_five_reg.delay_sel;
	assign slot_five_entry_value  = slot_five_reg.entry_value;

	// Register writes and reads
	always_comb begin
		slot_four_next = slot_four_reg;
		slot_five_next = slot_five_reg;
		rd_data_next   = rd_data_reg;
		// Writes store both fields
		if (reg_req_in.wr && reg_req_in.addr == wss_pkg::SLOT_FOUR_ADDR) begin
			slot_four_next = reg_req_in.wdata;
		end else if (reg_req_in.wr && reg_req_in.addr == wss_pkg::SLOT_FIVE_ADDR) begin
			slot_five_next = reg_req_in.wdata;
		end
		// Reads return the stored slot
		if (reg_req_in.rd) begin
			if (reg_req_in.addr == wss_pkg::SLOT_FOUR_ADDR) begin
				rd_data_next = {slot_four_delay_select, slot_four_entry_value};
			end else if (reg_req_in.addr == wss_pkg::SLOT_FIVE_ADDR) begin
				rd_data_next = {slot_five_delay_select, slot_five_entry_value};
			end else begin
				rd_data_next = wss_pkg::READ_UNMAPPED; // Foreign offset
			end
		end
	end

	// Register file flops
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			slot_four_reg <= wss_pkg::SLOT_RESET;
			slot_five_reg <= wss_pkg::SLOT_RESET;
			rd_data_reg   <= wss_pkg::READ_UNMAPPED;
		end else begin
			slot_four_reg <= slot_four_next;
			slot_five_reg <= slot_five_next;
			rd_data_reg   <= rd_data_next;
		end
	end

	// Pick the current slot, local ones take priority
	always_comb begin
		slot_sel = 3'(addr_reg - wss_pkg::SEQ_FIRST_ADDR);
		if (addr_reg == wss_pkg::SLOT_FOUR_ADDR) begin
			cur_slot = slot_four_reg;
		end else if (addr_reg == wss_pkg::SLOT_FIVE_ADDR) begin
			cur_slot = slot_five_reg;
		end else begin
			cur_slot = other_slots_in[slot_sel];
		end
	end

	// Sequencer next state
	always_comb begin
		state_next = state_reg;
		addr_next  = addr_reg;
		unit_next  = unit_reg;
		tick_next  = tick_reg;
		start_next = 1'b0;
		index_next = index_reg;
		done_next  = 1'b0;
		advance    = 1'b0;
		case (state_reg)
			wss_pkg::WSS_IDLE: begin
				// Go always begins at the first slot
				if (go_in) begin
					addr_next  = wss_pkg::SEQ_FIRST_ADDR;
					state_next = wss_pkg::WSS_FETCH;
				end
			end
			wss_pkg::WSS_FETCH: begin
				if (cur_slot.entry_value == wss_pkg::ENTRY_STOP) begin
					// Zero entry ends the sequence here
					state_next = wss_pkg::WSS_IDLE;
					done_next  = 1'b1;
				end else if (cur_slot.delay_sel) begin
					// Value counts delay steps, no waveform
					state_next = wss_pkg::WSS_WAIT;
					unit_next  = cur_slot.entry_value;
					tick_next  = TICK_LOAD;
				end else begin
					// Value is a library position
					state_next = wss_pkg::WSS_PLAY;
					start_next = 1'b1;
					index_next = cur_slot.entry_value;
				end
			end
			wss_pkg::WSS_PLAY: begin
				// Effect end moves on
				if (effect_done_in) begin
					advance = 1'b1;
				end
			end
			wss_pkg::WSS_WAIT: begin
				// Step count times step length
				if (tick_reg != '0) begin
					tick_next = tick_reg - 1'b1;
				end else if (unit_reg > 7'h01) begin
					unit_next = unit_reg - 7'h01;
					tick_next = TICK_LOAD;
				end else begin
					advance = 1'b1;
				end
			end
			default: begin
				state_next = wss_pkg::WSS_IDLE; // Recover from a bad code
			end
		endcase
		// Finished slot: end at the last, else next
		if (advance) begin
			if (addr_reg == wss_pkg::SEQ_LAST_ADDR) begin
				state_next = wss_pkg::WSS_IDLE;
				done_next  = 1'b1;
			end else begin
				addr_next  = addr_reg + 8'h01;
				state_next = wss_pkg::WSS_FETCH;
			end
		end
	end

	// Sequencer flops
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_reg <= wss_pkg::WSS_IDLE;
			addr_reg  <= wss_pkg::SEQ_FIRST_ADDR;
			unit_reg  <= 7'h00;
			tick_reg  <= '0;
			start_reg <= 1'b0;
			index_reg <= 7'h00;
			done_reg  <= 1'b0;
			delay_reg <= 1'b0;
			busy_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg  <= addr_next;
			unit_reg  <= unit_next;
			tick_reg  <= tick_next;
			start_reg <= start_next;
			index_reg <= index_next;
			done_reg  <= done_next;
			delay_reg <= (state_next == wss_pkg::WSS_WAIT);
			busy_reg  <= (state_next != wss_pkg::WSS_IDLE);
		end
	end

	// Outputs straight from flops
	assign rd_data_out      = rd_data_reg;
	assign effect_start_out = start_reg;
	assign effect_index_out = index_reg;
	assign delay_active_out = delay_reg;
	assign busy_out         = busy_reg;
	assign seq_done_out     = done_reg;
	assign slot_addr_out    = addr_reg;

	// Go from idle lands on the first slot
	property p_go_first;
		@(posedge clk_in) disable iff (reset_in)
		(state_reg == wss_pkg::WSS_IDLE && go_in) |=>
			(addr_reg == wss_pkg::SEQ_FIRST_ADDR && state_reg == wss_pkg::WSS_FETCH);
	endproperty
	a_go_first: assert property (p_go_first) else $error("go did not start at first slot");

	// Zero entry stops with a done pulse
	property p_zero_stop;
		@(posedge clk_in) disable iff (reset_in)
		(state_reg == wss_pkg::WSS_FETCH && cur_slot.entry_value == 7'h00) |=>
			(seq_done_out && !effect_start_out && state_reg == wss_pkg::WSS_IDLE);
	endproperty
	a_zero_stop: assert property (p_zero_stop) else $error("zero entry did not stop");

	// Effect slot issues its index
	property p_effect_start;
		@(posedge clk_in) disable iff (reset_in)
		(state_reg == wss_pkg::WSS_FETCH && !cur_slot.delay_sel && cur_slot.entry_value != 7'h00)
			|=> (effect_start_out && effect_index_out == $past(cur_slot.entry_value) && !delay_active_out);
	endproperty
	a_effect_start: assert property (p_effect_start) else $error("effect not started");

	// Index comes from the low seven bits
	property p_index_bits;
		@(posedge clk_in) disable iff (reset_in)
		effect_start_out |-> (effect_index_out == $past(cur_slot.entry_value, 1) && busy_out);
	endproperty
	a_index_bits: assert property (p_index_bits) else $error("wrong effect index");

	// Delay slot idles with no effect
	property p_delay_idle;
		@(posedge clk_in) disable iff (reset_in)
		(state_reg == wss_pkg::WSS_FETCH && cur_slot.delay_sel && cur_slot.entry_value != 7'h00)
			|=> (delay_active_out && !effect_start_out && unit_reg == $past(cur_slot.entry_value))
			##1 (!effect_start_out);
	endproperty
	a_delay_idle: assert property (p_delay_idle) else $error("delay slot not idled");

	// Tick counts down one per cycle in a step
	property p_tick_down;
		@(posedge clk_in) disable iff (reset_in)
		(state_reg == wss_pkg::WSS_WAIT && tick_reg != '0) |=>
			(state_reg == wss_pkg::WSS_WAIT && tick_reg == $past(tick_reg) - 1'b1
			&& unit_reg == $past(unit_reg));
	endproperty
	a_tick_down: assert property (p_tick_down) else $error("delay tick wrong");

	// Step end with steps left reloads the tick
	property p_step_end;
		@(posedge clk_in) disable iff (reset_in)
		(state_reg == wss_pkg::WSS_WAIT && tick_reg == '0 && unit_reg > 7'h01) |=>
			(tick_reg == TICK_LOAD && unit_reg == $past(unit_reg) - 7'h01);
	endproperty
	a_step_end: assert property (p_step_end) else $error("delay step not reloaded");

	// Delay expiry and effect end advance alike
	property p_advance;
		@(posedge clk_in) disable iff (reset_in)
		(((state_reg == wss_pkg::WSS_PLAY && effect_done_in) ||
		  (state_reg == wss_pkg::WSS_WAIT && tick_reg == '0 && unit_reg <= 7'h01))
		 && addr_reg != wss_pkg::SEQ_LAST_ADDR) |=>
			(state_reg == wss_pkg::WSS_FETCH && addr_reg == $past(addr_reg) + 8'h01);
	endproperty
	a_advance: assert property (p_advance) else $error("slot did not advance");

	// Playing slot waits for effect end
	property p_play_hold;
		@(posedge clk_in) disable iff (reset_in)
		(state_reg == wss_pkg::WSS_PLAY && !effect_done_in) |=>
			(state_reg == wss_pkg::WSS_PLAY && addr_reg == $past(addr_reg));
	endproperty
	a_play_hold: assert property (p_play_hold) else $error("left slot early");

	// Effect end on the last slot ends the sequence
	property p_last_end;
		@(posedge clk_in) disable iff (reset_in)
		(state_reg == wss_pkg::WSS_PLAY && effect_done_in && addr_reg == wss_pkg::SEQ_LAST_ADDR)
			|=> (seq_done_out && !busy_out) ##1 !seq_done_out;
	endproperty
	a_last_end: assert property (p_last_end) else $error("no end after last slot");

	// Reset clears slot four, a read right after reset returns zero
	property p_slot_rw;
		@(posedge clk_in)
		(reset_in ##1 (reg_req_in.rd && reg_req_in.addr == wss_pkg::SLOT_FOUR_ADDR
			&& !reset_in)) |=> (rd_data_out == 8'h00 || $past(reg_req_in.wr, 2));
	endproperty
	a_slot_rw: assert property (p_slot_rw) else $error("slot not zero after reset");

endmodule

`default_nettype wire

// file: tb/wss_sequencer_bench.sv
// Self-checking bench for the waveform sequence slot block
`timescale 1ns/10ps
`default_nettype none

module wss_sequencer_bench;
	localparam int UNIT = 4; // Short delay step for simulation

	logic                           clk_in;       // Core clock
	logic                           reset_in;     // Synchronous reset
	wss_pkg::wss_reg_req_t          reg_req;      // Register request
	logic                           go;           // Start pulse
	wss_pkg::wss_slot_t [7:0]       other_slots;  // External slot contents
	logic                           effect_done;  // Effect finished
	wire logic [7:0]                rd_data;      // Read data
	wire logic                      effect_start; // Effect fetch pulse
	wire logic [6:0]                effect_index; // Library index
	wire logic                      delay_active; // Timed idle
	wire logic                      busy;         // Sequence running
	wire logic                      seq_done;     // End pulse
	wire logic [7:0]                slot_addr;    // Current slot
	int                             fail_count;   // Mismatches seen
	int                             comparisons;  // Checks made
	logic [7:0]                     seqs [3][8];  // Sequence table

	wss_sequencer #(.DELAY_UNIT_CYCLES(UNIT)) dut (
		.clk_in           (clk_in),
		.reset_in         (reset_in),
		.reg_req_in       (reg_req),
		.go_in            (go),
		.other_slots_in   (other_slots),
		.effect_done_in   (effect_done),
		.rd_data_out      (rd_data),
		.effect_start_out (effect_start),
		.effect_index_out (effect_index),
		.delay_active_out (delay_active),
		.busy_out         (busy),
		.seq_done_out     (seq_done),
		.slot_addr_out    (slot_addr)
	);

	// Clock at 100 MHz
	always #5 clk_in = ~clk_in;

	// Step past the next rising edge by a fixed small delay
	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask

	// Compare one value and count it
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One-cycle write strobe, then an idle edge before the next request
	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		reg_req = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		tick();
		reg_req = '0;
		tick();
	endtask

	// One-cycle read strobe, data compared once registered
	task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
		reg_req = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		tick();
		reg_req = '0;
		tick();
		check("read data", exp, rd_data);
	endtask

	// Load a sequence, start it and follow it slot by slot
	task automatic run_seq(input int s);
		int n;
		for (int i = 0; i < 8; i++) begin
			// Outside copies of slots four and five read zero: play must use the registers
			other_slots[i] = (i == 3 || i == 4) ? '0 : wss_pkg::wss_slot_t'(seqs[s][i]);
		end
		reg_write(wss_pkg::SLOT_FOUR_ADDR, seqs[s][3]);
		reg_write(wss_pkg::SLOT_FIVE_ADDR, seqs[s][4]);
		go = 1'b1;
		tick();
		go = 1'b0;
		check("busy after go", 8'h01, {7'h00, busy});
		for (int i = 0; i < 8; i++) begin
			check("slot address", 8'h0f + 8'(i), slot_addr);
			tick();
			if (seqs[s][i][6:0] == 7'h00) begin
				check("stop pulse", 8'h01, {7'h00, seq_done});
				check("busy at stop", 8'h00, {7'h00, busy});
				check("no effect at stop", 8'h00, {7'h00, effect_start});
				return;
			end
			if (seqs[s][i][7]) begin
				// Delay slot: count the idle cycles
				check("idle level", 8'h01, {7'h00, delay_active});
				check("no effect in idle", 8'h00, {7'h00, effect_start});
				n = 0;
				while (delay_active === 1'b1 && n < 1000) begin
					n++;
					tick();
				end
				check("idle length", 8'(seqs[s][i][6:0] * UNIT), 8'(n));
			end else begin
				// Effect slot: start, a refused go, then finish
				check("effect start", 8'h01, {7'h00, effect_start});
				check("effect index", {1'b0, seqs[s][i][6:0]}, {1'b0, effect_index});
				go = 1'b1;
				tick();
				go = 1'b0;
				tick();
				check("address held while playing", 8'h0f + 8'(i), slot_addr);
				check("single start pulse", 8'h00, {7'h00, effect_start});
				// Done taken at this edge: next slot address stands right after it
				effect_done = 1'b1;
				tick();
				effect_done = 1'b0;
			end
		end
		check("end after last slot", 8'h01, {7'h00, seq_done});
		check("busy after last slot", 8'h00, {7'h00, busy});
	endtask

	// Verdict and end of run
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		#200000;
		fail_count++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		clk_in      = 1'b0;
		reset_in    = 1'b1;
		reg_req     = '0;
		go          = 1'b0;
		other_slots = '0;
		effect_done = 1'b0;
		fail_count  = 0;
		comparisons = 0;
		// Full run with delays, stop at a select-set zero, stop at first slot
		seqs[0] = '{8'h11, 8'h82, 8'h05, 8'h83, 8'h2a, 8'h07, 8'h01, 8'h7f};
		seqs[1] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h80, 8'h06, 8'h07, 8'h08};
		seqs[2] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08};
		repeat (3) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
		check("address after reset", 8'h0f, slot_addr);
		reg_read(wss_pkg::SLOT_FOUR_ADDR, 8'h00);
		reg_read(wss_pkg::SLOT_FIVE_ADDR, 8'h00);
		reg_write(wss_pkg::SLOT_FOUR_ADDR, 8'hd5);
		reg_write(wss_pkg::SLOT_FIVE_ADDR, 8'h6a);
		reg_write(8'h14, 8'hff);
		reg_read(wss_pkg::SLOT_FOUR_ADDR, 8'hd5);
		reg_read(wss_pkg::SLOT_FIVE_ADDR, 8'h6a);
		reg_read(8'h14, 8'h00);
		for (int s = 0; s < 3; s++) begin
			run_seq(s);
			tick();
		end
		// Reset clears written slots again
		reset_in = 1'b1;
		tick();
		reset_in = 1'b0;
		reg_read(wss_pkg::SLOT_FIVE_ADDR, 8'h00);
		report_and_stop();
	end
endmodule

`default_nettype wire
